/* hw/hssg_cfg.svh */
// Constants of the host service state gate: command codes, state codes, timing.
// Assumes inclusion by the package and the design modules; definitions only.
`ifndef HSSG_CFG_SVH
`define HSSG_CFG_SVH

`define HSSG_CMD_RESET        8'h01
`define HSSG_CMD_STATE        8'h02
`define HSSG_CMD_SET_BUSY     8'h03
`define HSSG_CMD_QUIT_BUSY    8'h04
`define HSSG_CMD_BUSMON       8'h05
`define HSSG_CMD_OFFSET_LO    8'h08
`define HSSG_CMD_OFFSET_HI    8'h0c
`define HSSG_CMD_SYS_STAT     8'h0d
`define HSSG_CMD_HALT         8'h0e
`define HSSG_CMD_LEAVE_HALT   8'h0f
`define HSSG_CMD_ACK_LO       8'h10
`define HSSG_CMD_ACK_HI       8'h17
`define HSSG_CMD_CONF_LO      8'h18
`define HSSG_CMD_CONF_HI      8'h1f
`define HSSG_CMD_IWR_LO       8'h28
`define HSSG_CMD_IWR_HI       8'h2b
`define HSSG_CMD_IRD_LO       8'h38
`define HSSG_CMD_IRD_HI       8'h3b
`define HSSG_CMD_END_LO       8'h47
`define HSSG_CMD_END_HI       8'h7f
`define HSSG_CMD_START        8'h80
`define HSSG_CMD_CONT_LO      8'h81
`define HSSG_CMD_CONT_HI      8'hbf
`define HSSG_CMD_POLL_LO      8'he0
`define HSSG_CMD_POLL_HI      8'hee
`define HSSG_CMD_SET_ADDR     8'hf1
`define HSSG_CMD_SET_RETRY    8'hf2

`define HSSG_CODE_POWER_UP    2'h0
`define HSSG_CODE_SYNC        2'h1
`define HSSG_CODE_STOP        2'h2
`define HSSG_CODE_NORMAL      2'h3

`define HSSG_LEN_ONE          3'h1
`define HSSG_LEN_TWO          3'h2
`define HSSG_LEN_FOUR         3'h4

`define HSSG_SILENCE_BITS     40
`define HSSG_BIT_NS           104167
`define HSSG_CLK_NS           20
`define HSSG_OFFSET_IDX_MSB   2

`endif

/* hw/hssg_pkg.sv */
// Types of the host service state gate.
// Assumes the constants header is on the include path.
`include "hssg_cfg.svh"

package hssg_pkg;

  typedef enum logic [4:0] {
    HSSG_ST_RESET    = 5'h01,
    HSSG_ST_POWER_UP = 5'h02,
    HSSG_ST_SYNC     = 5'h04,
    HSSG_ST_STOP     = 5'h08,
    HSSG_ST_NORMAL   = 5'h10
  } hssg_state_t;

  typedef enum logic [1:0] {
    HSSG_ACT_EXECUTE = 2'h0,
    HSSG_ACT_IGNORE  = 2'h1,
    HSSG_ACT_REJECT  = 2'h2
  } hssg_action_t;

  // Decoded service classes
  typedef enum logic [4:0] {
    HSSG_SVC_RESET, HSSG_SVC_STATE, HSSG_SVC_SET_BUSY, HSSG_SVC_QUIT_BUSY,
    HSSG_SVC_BUSMON, HSSG_SVC_SET_ADDR, HSSG_SVC_SET_RETRY, HSSG_SVC_OFFSET,
    HSSG_SVC_SYS_STAT, HSSG_SVC_HALT, HSSG_SVC_LEAVE_HALT, HSSG_SVC_ACK,
    HSSG_SVC_CONF, HSSG_SVC_IWR, HSSG_SVC_IRD, HSSG_SVC_START, HSSG_SVC_CONT,
    HSSG_SVC_END, HSSG_SVC_POLL, HSSG_SVC_UNKNOWN
  } hssg_service_t;

  typedef struct packed {
    hssg_service_t service;
    logic [2:0]    length;
  } hssg_decode_t;

  // One completed command handed to the user side
  typedef struct packed {
    hssg_service_t service;
    logic [7:0]    control;
    logic [7:0]    arg1;
    logic [7:0]    arg2;
    logic [7:0]    arg3;
  } hssg_command_t;

  typedef struct packed {
    logic bus_ok;
    logic filter_ok;
    logic xtal_ok;
  } hssg_supply_t;

endpackage

/* hw/hssg_decoder.sv */
// Control-byte decoder: service class and total byte count of a command.
// Assumes a stable control byte; purely combinational.
`timescale 1ns/10ps

module hssg_decoder
  import hssg_pkg::*;
(
  // Control byte in
  input  wire logic [7:0] control,
  // Decoded service out
  output hssg_decode_t    decoded
);

  always_comb
  begin
    decoded.length  = `HSSG_LEN_ONE;
    decoded.service = HSSG_SVC_UNKNOWN;
    if (control == `HSSG_CMD_RESET)
      decoded.service = HSSG_SVC_RESET;
    else if (control == `HSSG_CMD_STATE)
      decoded.service = HSSG_SVC_STATE;
    else if (control == `HSSG_CMD_SET_BUSY)
      decoded.service = HSSG_SVC_SET_BUSY;
    else if (control == `HSSG_CMD_QUIT_BUSY)
      decoded.service = HSSG_SVC_QUIT_BUSY;
    else if (control == `HSSG_CMD_BUSMON)
      decoded.service = HSSG_SVC_BUSMON;
    else if (control >= `HSSG_CMD_OFFSET_LO && control <= `HSSG_CMD_OFFSET_HI)
      decoded.service = HSSG_SVC_OFFSET;
    else if (control == `HSSG_CMD_SYS_STAT)
      decoded.service = HSSG_SVC_SYS_STAT;
    else if (control == `HSSG_CMD_HALT)
      decoded.service = HSSG_SVC_HALT;
    else if (control == `HSSG_CMD_LEAVE_HALT)
      decoded.service = HSSG_SVC_LEAVE_HALT;
    else if (control >= `HSSG_CMD_ACK_LO && control <= `HSSG_CMD_ACK_HI)
      decoded.service = HSSG_SVC_ACK;
    else if (control >= `HSSG_CMD_CONF_LO && control <= `HSSG_CMD_CONF_HI)
      decoded.service = HSSG_SVC_CONF;
    else if (control >= `HSSG_CMD_IWR_LO && control <= `HSSG_CMD_IWR_HI)
    begin
      decoded.service = HSSG_SVC_IWR;
      decoded.length  = `HSSG_LEN_TWO;
    end
    else if (control >= `HSSG_CMD_IRD_LO && control <= `HSSG_CMD_IRD_HI)
      decoded.service = HSSG_SVC_IRD;
    else if (control >= `HSSG_CMD_END_LO && control <= `HSSG_CMD_END_HI)
    begin
      decoded.service = HSSG_SVC_END;
      decoded.length  = `HSSG_LEN_TWO;
    end
    else if (control == `HSSG_CMD_START)
    begin
      decoded.service = HSSG_SVC_START;
      decoded.length  = `HSSG_LEN_TWO;
    end
    else if (control >= `HSSG_CMD_CONT_LO && control <= `HSSG_CMD_CONT_HI)
    begin
      decoded.service = HSSG_SVC_CONT;
      decoded.length  = `HSSG_LEN_TWO;
    end
    else if (control >= `HSSG_CMD_POLL_LO && control <= `HSSG_CMD_POLL_HI)
    begin
      decoded.service = HSSG_SVC_POLL;
      decoded.length  = `HSSG_LEN_FOUR;
    end
    else if (control == `HSSG_CMD_SET_ADDR)
    begin
      decoded.service = HSSG_SVC_SET_ADDR;
      decoded.length  = `HSSG_LEN_FOUR;
    end
    else if (control == `HSSG_CMD_SET_RETRY)
    begin
      decoded.service = HSSG_SVC_SET_RETRY;
      decoded.length  = `HSSG_LEN_FOUR;
    end
  end

endmodule

/* hw/hssg_sync2.sv */
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs are quasi-static levels; no multi-bit coherence implied.
`timescale 1ns/10ps

module hssg_sync2
  import hssg_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg;

  initial
  begin
    if (WIDTH < 1)
      $error("hssg_sync2: WIDTH must be at least 1");
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage_reg <= '0;
      sync_out  <= '0;
    end
    else
    begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end

endmodule

/* hw/hssg_gate.sv */
// Host service state gate: operating-state machine and command acceptance.
// Assumes host bytes arrive already deframed as one-cycle strobes on clk.
// Supervision flags and bus line are asynchronous pins and are synchronised here.
//
// Function
// R1 - Power-on or a host reset request puts the gate in reset, where it clears all features and discards every service.
// R2 - After reset, or on any supply or crystal fault, the gate sits in power-up, forbids bus traffic and reports code 00.
// R3 - Sync waits for at least 40 bit times of bus silence, with the receiver on but nothing forwarded, and reports 01.
// R4 - Stop suspends bus reception so the host can configure safely, and reports code 10.
// R5 - Normal permits bus communication and reports code 11.
// R6 - While the reset output is high, a system-status query is answered with a report carrying the state code.
// R7 - An ignored service is neither executed nor answered.
// R8 - A rejected service is not executed and raises a protocol error in the state indication.
// R9 - Acknowledge and frame first, middle and last byte requests are rejected outside normal; under bus monitor the code ignores them instead.
// R10 - Bus monitor is a flag over the underlying state, which keeps being tracked.
// R11 - Under bus monitor only reset, halt, leave-halt, internal write and internal read are executed.
// R12 - Halt is ignored only in stop; leave-halt is executed only in stop or under bus monitor.
// R13 - Codes 01 to 05 decode as reset, state, assert-busy, release-busy and bus-monitor, none of them bus traffic.
// R14 - Set-address is F1 plus high, low and a spare byte, acted on only once all four are in.
// R15 - Codes 08 to 0C are the frame index offset with index in the low three bits; 0D is the status query.
// R16 - Leaving stop goes through sync before normal.
// R17 - Power-up moves to sync once all supervision is healthy and back on any flag drop.
`timescale 1ns/10ps

module hssg_gate
  import hssg_pkg::*;
#(
  parameter int SILENCE_CYCLES = (`HSSG_SILENCE_BITS * `HSSG_BIT_NS + `HSSG_CLK_NS - 1)
                                 / `HSSG_CLK_NS
)
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Host byte stream
  input  wire logic          host_byte_valid,
  input  wire logic [7:0]    host_byte,
  // Supervision pins and bus line
  input  wire logic          bus_voltage_ok,
  input  wire logic          filter_voltage_ok,
  input  wire logic          xtal_ok,
  input  wire logic          bus_line_idle,
  // Executed command out
  output logic               cmd_valid,
  output hssg_command_t      cmd,
  // Answers to host
  output logic               system_status_report,
  output logic               state_report,
  output logic [1:0]         state_code,
  output logic               protocol_error,
  // Status levels
  output logic               reset_out_n,
  output logic               bus_comm_enable,
  output logic               rx_forward_enable,
  output logic               bus_monitor,
  output logic               busy,
  output logic [15:0]        own_address,
  output logic [7:0]         retry_count,
  output logic [2:0]         frame_index_offset
);

  hssg_state_t   state_reg;
  hssg_state_t   state_next;
  hssg_supply_t  supply_sync;
  logic          line_idle_sync;
  logic [$clog2(SILENCE_CYCLES+1)-1:0] silence_reg;
  logic          silence_done;
  logic [2:0]    count_reg;
  logic [2:0]    need_reg;
  hssg_command_t collect_reg;
  hssg_decode_t  decoded;
  hssg_action_t  action;
  logic          supply_ok;
  logic          cmd_done;
  hssg_command_t cmd_now;
  logic          exec;
  logic          reject;

  initial
  begin
    if (SILENCE_CYCLES < 1)
      $error("hssg_gate: SILENCE_CYCLES must be at least 1");
  end

  hssg_sync2 #(.WIDTH(4)) u_sync
  (
    .clk      (clk),
    .rst      (rst),
    .async_in ({bus_voltage_ok, filter_voltage_ok, xtal_ok, bus_line_idle}),
    .sync_out ({supply_sync, line_idle_sync})
  );

  hssg_decoder u_decoder
  (
    .control (collect_reg.control),
    .decoded (decoded)
  );

  assign supply_ok    = supply_sync.bus_ok & supply_sync.filter_ok & supply_sync.xtal_ok;
  assign silence_done = (silence_reg == ($bits(silence_reg))'(SILENCE_CYCLES));

  // Byte collection: control byte first, then arguments
  // Count is cleared only on completion or in reset, so a cut command stalls here
  always_ff @(posedge clk)
  begin
    if (rst || state_reg == HSSG_ST_RESET)
    begin
      count_reg   <= '0;
      collect_reg <= '0;
    end
    else if (host_byte_valid)
    begin
      if (count_reg == 3'h0)
        collect_reg.control <= host_byte;
      else if (count_reg == 3'h1)
        collect_reg.arg1 <= host_byte;
      else if (count_reg == 3'h2)
        collect_reg.arg2 <= host_byte;
      else
        collect_reg.arg3 <= host_byte;
      count_reg <= count_reg + 3'h1;
    end
    else if (cmd_done)
      count_reg <= '0;
  end

  // Completed once all bytes of the command are in [R14]
  always_comb
  begin
    cmd_now         = collect_reg;
    cmd_now.service = decoded.service;
    cmd_done        = (count_reg != 3'h0) && (count_reg >= decoded.length) && !host_byte_valid;
  end

  // Acceptance by state and bus-monitor overlay
  always_comb
  begin
    action = HSSG_ACT_EXECUTE;
    if (bus_monitor)
    begin
      unique case (decoded.service) // [R11]
        HSSG_SVC_RESET, HSSG_SVC_HALT, HSSG_SVC_LEAVE_HALT, HSSG_SVC_IWR, HSSG_SVC_IRD:
          action = HSSG_ACT_EXECUTE;
        default:
          action = HSSG_ACT_IGNORE;
      endcase
    end
    else
    begin
      unique case (decoded.service)
        HSSG_SVC_ACK, HSSG_SVC_START, HSSG_SVC_CONT, HSSG_SVC_END:
          action = (state_reg == HSSG_ST_NORMAL) ? HSSG_ACT_EXECUTE : HSSG_ACT_REJECT; // [R9]
        HSSG_SVC_HALT:
          action = (state_reg == HSSG_ST_STOP) ? HSSG_ACT_IGNORE : HSSG_ACT_EXECUTE; // [R12]
        HSSG_SVC_LEAVE_HALT:
          action = (state_reg == HSSG_ST_STOP) ? HSSG_ACT_EXECUTE : HSSG_ACT_IGNORE; // [R12]
        HSSG_SVC_UNKNOWN:
          action = HSSG_ACT_IGNORE;
        default:
          action = HSSG_ACT_EXECUTE;
      endcase
    end
  end

  assign exec = cmd_done && (action == HSSG_ACT_EXECUTE) && (state_reg != HSSG_ST_RESET); // [R1]

  assign reject = cmd_done && (action == HSSG_ACT_REJECT) && (state_reg != HSSG_ST_RESET);

  // Bus silence counter, runs only in sync
  // Saturates so a long idle spell cannot wrap back to zero
  always_ff @(posedge clk)
  begin
    if (rst || state_reg != HSSG_ST_SYNC || !line_idle_sync)
      silence_reg <= '0;
    else if (!silence_done)
      silence_reg <= silence_reg + 1'b1; // [R3]
  end

  // Operating state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      HSSG_ST_RESET:
        state_next = HSSG_ST_POWER_UP; // [R2]
      HSSG_ST_POWER_UP:
        if (supply_ok)
          state_next = HSSG_ST_SYNC; // [R17]
      HSSG_ST_SYNC:
        if (silence_done)
          state_next = HSSG_ST_NORMAL; // [R3]
      HSSG_ST_STOP:
        if (exec && decoded.service == HSSG_SVC_LEAVE_HALT)
          state_next = HSSG_ST_SYNC; // [R16]
      HSSG_ST_NORMAL:
        state_next = HSSG_ST_NORMAL;
      default:
        state_next = HSSG_ST_RESET;
    endcase
    // Later overrides win: host reset over supply fault over halt
    if (state_reg != HSSG_ST_RESET && exec && decoded.service == HSSG_SVC_HALT)
      state_next = HSSG_ST_STOP; // [R4]
    if (state_reg != HSSG_ST_RESET && !supply_ok)
      state_next = HSSG_ST_POWER_UP; // [R2] [R17]
    if (exec && decoded.service == HSSG_SVC_RESET)
      state_next = HSSG_ST_RESET; // [R1]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_reg <= HSSG_ST_RESET; // [R1]
    else
      state_reg <= state_next;
  end

  // Bus-monitor overlay, kept apart from the state [R10]
  always_ff @(posedge clk)
  begin
    if (rst || state_reg == HSSG_ST_RESET)
      bus_monitor <= 1'b0;
    else if (exec && decoded.service == HSSG_SVC_BUSMON)
      bus_monitor <= 1'b1;
    else if (exec && decoded.service == HSSG_SVC_LEAVE_HALT && bus_monitor)
      bus_monitor <= 1'b0; // [R12]
  end

  // Features set by internal commands [R13] [R15]
  always_ff @(posedge clk)
  begin
    if (rst || state_reg == HSSG_ST_RESET)
    begin
      busy               <= 1'b0;
      own_address        <= '0;
      retry_count        <= '0;
      frame_index_offset <= '0;
    end
    else if (exec)
    begin
      if (decoded.service == HSSG_SVC_SET_BUSY)
        busy <= 1'b1;
      if (decoded.service == HSSG_SVC_QUIT_BUSY)
        busy <= 1'b0;
      if (decoded.service == HSSG_SVC_SET_ADDR)
        own_address <= {collect_reg.arg1, collect_reg.arg2}; // [R14]
      if (decoded.service == HSSG_SVC_SET_RETRY)
        retry_count <= collect_reg.arg1;
      if (decoded.service == HSSG_SVC_OFFSET)
        frame_index_offset <= collect_reg.control[`HSSG_OFFSET_IDX_MSB:0]; // [R15]
    end
  end

  // Answers: executed command, status report, state indication
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_valid            <= 1'b0;
      cmd                  <= '0;
      system_status_report <= 1'b0;
      state_report         <= 1'b0;
      protocol_error       <= 1'b0;
    end
    else
    begin
      cmd_valid            <= exec; // [R7]
      cmd                  <= exec ? cmd_now : cmd;
      system_status_report <= exec && reset_out_n
                              && decoded.service == HSSG_SVC_SYS_STAT; // [R6]
      state_report         <= (exec && decoded.service == HSSG_SVC_STATE)
                              || (cmd_done && action == HSSG_ACT_REJECT
                                  && state_reg != HSSG_ST_RESET); // [R8]
      // Sticky until a state request reads it out, or reset clears it
      if (reject)
        protocol_error <= 1'b1; // [R8]
      else if (exec && decoded.service == HSSG_SVC_STATE)
        protocol_error <= 1'b0;
      else if (state_reg == HSSG_ST_RESET)
        protocol_error <= 1'b0; // [R1]
    end
  end

  // Level outputs derived from the state
  // Taken from state_next so each output is a flop yet in step with the state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reset_out_n       <= 1'b0;
      state_code        <= `HSSG_CODE_POWER_UP;
      bus_comm_enable   <= 1'b0;
      rx_forward_enable <= 1'b0;
    end
    else
    begin
      reset_out_n       <= (state_next != HSSG_ST_RESET);
      bus_comm_enable   <= (state_next == HSSG_ST_NORMAL); // [R2] [R5]
      rx_forward_enable <= (state_next == HSSG_ST_NORMAL); // [R3] [R4]
      unique case (state_next)
        HSSG_ST_SYNC:   state_code <= `HSSG_CODE_SYNC;   // [R3]
        HSSG_ST_STOP:   state_code <= `HSSG_CODE_STOP;   // [R4]
        HSSG_ST_NORMAL: state_code <= `HSSG_CODE_NORMAL; // [R5]
        default:        state_code <= `HSSG_CODE_POWER_UP; // [R2]
      endcase
    end
  end

endmodule

/* bench/hssg_gate_checker.sv */
// Concurrent checks on the ports of the host service state gate.
// Assumes binding into hssg_gate; one clock, synchronous reset.
`timescale 1ns/10ps

module hssg_gate_checker
  import hssg_pkg::*;
#(
  parameter int SILENCE_CYCLES = 16
)
(
  // Clock and reset
  input wire logic    clk,
  input wire logic    rst,
  // Bus line
  input wire logic    bus_line_idle,
  // Outputs watched
  input wire logic    cmd_valid,
  input hssg_command_t cmd,
  input wire logic    system_status_report,
  input wire logic    state_report,
  input wire logic [1:0] state_code,
  input wire logic    protocol_error,
  input wire logic    reset_out_n,
  input wire logic    bus_comm_enable,
  input wire logic    rx_forward_enable,
  input wire logic    bus_monitor,
  input wire logic    busy,
  input wire logic [15:0] own_address,
  input wire logic [2:0] frame_index_offset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Consecutive raw idle cycles, saturating
  int idle_cnt;
  always_ff @(posedge clk)
    if (rst || !bus_line_idle)
      idle_cnt <= 0;
    else if (idle_cnt < SILENCE_CYCLES + 8)
      idle_cnt <= idle_cnt + 1;

  reset_quiet_a: assert property (!reset_out_n |-> state_code == 2'h0 && !state_report
    && !system_status_report) else $error("activity while reset output low");
  reset_clears_a: assert property (!reset_out_n |=> !busy && !bus_monitor)
    else $error("features not cleared by reset");
  comm_normal_a: assert property (bus_comm_enable |-> state_code == 2'h3)
    else $error("bus traffic outside normal");
  fwd_normal_a: assert property (rx_forward_enable |-> state_code == 2'h3)
    else $error("frames forwarded outside normal");
  sync_silence_a: assert property ($past(state_code) == 2'h1 && state_code == 2'h3
    |-> idle_cnt >= SILENCE_CYCLES - 1) else $error("left sync without silence");
  status_gate_a: assert property (system_status_report |-> reset_out_n)
    else $error("status report with reset output low");
  reject_report_a: assert property ($rose(protocol_error) |-> state_report)
    else $error("protocol error without state report");
  data_normal_a: assert property (cmd_valid && cmd.service inside {HSSG_SVC_ACK,
    HSSG_SVC_START, HSSG_SVC_CONT, HSSG_SVC_END} |-> state_code == 2'h3 && !bus_monitor)
    else $error("data request executed outside normal");
  monitor_only_a: assert property (cmd_valid && bus_monitor && $past(bus_monitor, 3)
    |-> cmd.service inside {HSSG_SVC_RESET, HSSG_SVC_HALT, HSSG_SVC_LEAVE_HALT,
    HSSG_SVC_IWR, HSSG_SVC_IRD}) else $error("service executed under monitor");
  addr_load_a: assert property (cmd_valid && cmd.service == HSSG_SVC_SET_ADDR
    |-> own_address == {cmd.arg1, cmd.arg2}) else $error("address not loaded");
  offset_load_a: assert property (cmd_valid && cmd.service == HSSG_SVC_OFFSET
    |-> frame_index_offset == cmd.control[2:0]) else $error("offset not loaded");
endmodule

bind hssg_gate hssg_gate_checker #(.SILENCE_CYCLES(SILENCE_CYCLES)) i_checker (.*);

/* bench/hssg_host_model.sv */
// Host model: sends whole commands as byte strobes on clk.
// Assumes callers wait for the answer window before the next command.
`timescale 1ns/10ps

module hssg_host_model
(
  // Clock
  input wire logic        clk,
  // Byte stream
  output logic            host_byte_valid,
  output logic [7:0]      host_byte
);
  initial
  begin
    host_byte_valid = 1'b0;
    host_byte = 8'h00;
  end

  // Stale data inverted once released
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      @(posedge clk);
      host_byte_valid <= 1'b1;
      host_byte <= q[i];
    end
    @(posedge clk);
    host_byte_valid <= 1'b0;
    host_byte <= ~q[q.size()-1];
  endtask
endmodule

/* bench/hssg_gate_tb_top.sv */
// Self-checking bench for the host service state gate with a service model.
// Assumes the checker is bound in; short silence count for simulation.
`timescale 1ns/10ps

module hssg_gate_tb_top
  import hssg_pkg::*;
;
  logic clk, rst, host_byte_valid, bus_voltage_ok, filter_voltage_ok, xtal_ok, bus_line_idle;
  logic [7:0] host_byte;
  logic cmd_valid, system_status_report, state_report, protocol_error, reset_out_n;
  logic bus_comm_enable, rx_forward_enable, bus_monitor, busy;
  logic [1:0] state_code;
  logic [15:0] own_address;
  logic [7:0] retry_count;
  logic [2:0] frame_index_offset;
  hssg_command_t cmd;
  int fails, total_checks, seed, m_code, i;
  bit m_mon, m_perr;
  logic [31:0] r;

  hssg_gate #(.SILENCE_CYCLES(16)) i_dut (.clk(clk), .rst(rst),
    .host_byte_valid(host_byte_valid), .host_byte(host_byte),
    .bus_voltage_ok(bus_voltage_ok), .filter_voltage_ok(filter_voltage_ok),
    .xtal_ok(xtal_ok), .bus_line_idle(bus_line_idle), .cmd_valid(cmd_valid), .cmd(cmd),
    .system_status_report(system_status_report), .state_report(state_report),
    .state_code(state_code), .protocol_error(protocol_error), .reset_out_n(reset_out_n),
    .bus_comm_enable(bus_comm_enable), .rx_forward_enable(rx_forward_enable),
    .bus_monitor(bus_monitor), .busy(busy), .own_address(own_address),
    .retry_count(retry_count), .frame_index_offset(frame_index_offset));
  hssg_host_model i_host (.clk(clk), .host_byte_valid(host_byte_valid), .host_byte(host_byte));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Service model: 0 execute, 1 ignore, 2 reject
  function automatic int act(input int c, input int code, input bit mon);
    if (!(c inside {[1:5], [8:31], [40:43], [56:59], [71:191], [224:238], 241, 242}))
      return 1;
    if (mon)
      return (c == 1 || c == 14 || c == 15 || (c >= 40 && c <= 43) || (c >= 56 && c <= 59))
             ? 0 : 1;
    if (c == 14)
      return (code == 2) ? 1 : 0;
    if (c == 15)
      return (code == 2) ? 0 : 1;
    if ((c >= 16 && c <= 23) || (c >= 71 && c <= 191))
      return (code == 3) ? 0 : 2;
    return 0;
  endfunction

  task automatic issue(input logic [7:0] q[$]);
    int a, nc, nr, ns, nl;
    a = act(q[0], m_code, m_mon);
    nc = 0; nr = 0; ns = 0; nl = 0;
    i_host.send(q);
    repeat (5)
    begin
      @(posedge clk);
      #1;
      nc += (cmd_valid === 1'b1);
      nr += (state_report === 1'b1);
      ns += (system_status_report === 1'b1);
      nl += (reset_out_n === 1'b0);
    end
    if (a == 2)
      m_perr = 1;
    if (a == 0 && q[0] == 8'h02)
      m_perr = 0;
    if (a == 0 && q[0] == 8'h05)
      m_mon = 1;
    if (a == 0 && q[0] == 8'h0e)
      m_code = 2;
    if (a == 0 && q[0] == 8'h0f)
      if (m_mon) m_mon = 0; else m_code = 1;
    if (q[0] == 8'h01)
    begin
      check(nl > 0, 1);
      m_mon = 0;
      m_perr = 0;
    end
    else
    begin
      check(nc, a == 0);
      check(nr, a == 2 || (a == 0 && q[0] == 8'h02));
      check(ns, a == 0 && q[0] == 8'h0d);
      check(state_code, m_code);
      check(protocol_error, m_perr);
      check(bus_monitor, m_mon);
    end
  endtask

  task automatic wait_code(input logic [1:0] c);
    int n;
    n = 0;
    while (state_code !== c && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(state_code, c);
    m_code = c;
  endtask

  initial
  begin
    #200000;
    fails++;
    results();
  end

  initial
  begin
    seed = 11; fails = 0; total_checks = 0; m_code = 0; m_mon = 0; m_perr = 0;
    rst = 1'b1; bus_voltage_ok = 1'b1; filter_voltage_ok = 1'b1; xtal_ok = 1'b1;
    bus_line_idle = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_code(2'h3);
    check(bus_comm_enable, 1);
    check(rx_forward_enable, 1);
    issue('{8'h0d});
    issue('{8'h03});
    check(busy, 1);
    issue('{8'h04});
    check(busy, 0);
    for (i = 0; i < 5; i++)
    begin
      issue('{8'h08 + i[7:0]});
      check(frame_index_offset, i);
    end
    r = $random(seed);
    issue('{8'hf1, r[15:8], r[7:0], r[23:16]});
    check(own_address, r[15:0]);
    check({cmd.control, cmd.arg1, cmd.arg2}, {8'hf1, r[15:8], r[7:0]});
    issue('{8'hf2, r[23:16], r[31:24], r[7:0]});
    check(retry_count, r[23:16]);
    issue('{8'h06});
    issue('{8'h10});
    issue('{8'h0f});
    issue('{8'h0e});
    check(bus_comm_enable, 0);
    issue('{8'h0e});
    issue('{8'h0d});
    issue('{8'h18});
    issue('{8'h10});
    issue('{8'h80, r[31:24]});
    issue('{8'h81, r[7:0]});
    issue('{8'h47, r[15:8]});
    issue('{8'h02});
    issue('{8'h0f});
    bus_line_idle <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    check(state_code, 2'h1);
    check(rx_forward_enable, 0);
    bus_line_idle <= 1'b1;
    wait_code(2'h3);
    issue('{8'h05});
    issue('{8'h03});
    check(busy, 0);
    issue('{8'h0d});
    issue('{8'h02});
    issue('{8'hf2, ~r[23:16], 8'h00, 8'h00});
    check(retry_count, r[23:16]);
    issue('{8'h28, r[23:16]});
    issue('{8'h3b});
    issue('{8'h0f});
    bus_voltage_ok <= 1'b0;
    wait_code(2'h0);
    issue('{8'h17});
    issue('{8'he0, r[7:0], r[15:8], r[23:16]});
    issue('{8'h02});
    filter_voltage_ok <= 1'b0;
    bus_voltage_ok <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check(state_code, 2'h0);
    filter_voltage_ok <= 1'b1;
    wait_code(2'h1);
    wait_code(2'h3);
    issue('{8'h03});
    issue('{8'h01});
    check(busy, 0);
    wait_code(2'h3);
    results();
  end
endmodule
